// ### hdl/mcs_sequencer.sv
// Channel address sequencer with acquisition and conversion timing.
//
// Contract
// - Load low loads address on trigger fall.
// - Four select bits; gate off connects nothing.
// - Free-running: step on each flag fall.
// - Flag low: data old channel, index new.
// - Free-running scans all channels, wrapping.
// - Triggered: each trigger fall with load high steps once.
// - Conversion starts nine microseconds after step.
// - Clear low forces channel zero.
// - Acquisition end raises conversion flag.
// - Conversion ends in ten microseconds, data valid.
`timescale 1ns/10ps
module mcs_sequencer
  import mcs_pkg::*;
#(
  parameter bit DIFF_MODE = 1'b0,
  parameter int ACQ_CNT   = mcs_pkg::ACQ_CYCLES,
  parameter int CONV_CNT  = mcs_pkg::CONV_CYCLES
) (
  // Clock and reset.
  input  wire logic                       i_clk,
  input  wire logic                       i_sys_rst,
  // Control pins from the controller.
  input  wire logic                       i_sample_trigger_n,
  input  wire logic                       i_latch_select_n,
  input  wire logic                       i_counter_zero_n,
  input  wire logic                       i_channel_gate_on,
  input  wire logic                       i_sel_w8,
  input  wire logic                       i_sel_w4,
  input  wire logic                       i_sel_w2,
  input  wire logic                       i_sel_w1,
  // Sample from the converter core.
  input  wire logic [mcs_pkg::DATA_W-1:0] i_sample_data,
  // Status and channel outputs.
  output logic                            o_conversion_flag,
  output logic [mcs_pkg::ADDR_W-1:0]      o_channel_index_out,
  output logic                            o_channel_connected,
  output logic [mcs_pkg::DATA_W-1:0]      o_data,
  output logic                            o_data_oe_n
);
  import mcs_pkg::*;

  localparam logic [ADDR_W-1:0] ADDR_MASK = DIFF_MODE ? MASK_DIFF : MASK_SE;

  logic [7:0]        pins_s;
  logic              trig_s;
  logic              load_n_s;
  logic              clr_n_s;
  logic              gate_s;
  logic [ADDR_W-1:0] sel_s;
  logic              trig_d_r;
  logic              trig_fall;

  mcs_sync #(.W(8)) u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_sample_trigger_n, i_latch_select_n, i_counter_zero_n, i_channel_gate_on,
                 i_sel_w8, i_sel_w4, i_sel_w2, i_sel_w1}),
    .o_sync    (pins_s)
  );

  assign trig_s    = pins_s[7];
  assign load_n_s  = pins_s[6];
  assign clr_n_s   = pins_s[5];
  assign gate_s    = pins_s[4];
  assign sel_s     = pins_s[3:0];
  assign trig_fall = trig_d_r & ~trig_s;

  mcs_state_t        state_r;
  mcs_state_t        state_nxt;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [DATA_W-1:0] data_r;
  logic [DATA_W-1:0] data_nxt;
  logic              flag_r;
  logic              flag_nxt;
  logic              oe_n_r;
  logic              oe_n_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    addr_nxt  = addr_r;
    data_nxt  = data_r;
    flag_nxt  = flag_r;
    oe_n_nxt  = oe_n_r;
    // In free-running use the flag is looped to the trigger, so its fall steps too.
    if (!clr_n_s) begin
      addr_nxt = ADDR_RST;
    end else if (trig_fall && !load_n_s) begin
      addr_nxt = sel_s & ADDR_MASK;
    end else if (trig_fall) begin
      addr_nxt = (addr_r + 4'h1) & ADDR_MASK;
    end
    case (state_r)
      MCS_IDLE: begin
        if (trig_fall) begin
          state_nxt = MCS_ACQ;
          cnt_nxt   = CNT_W'(ACQ_CNT - 1);
        end
      end
      MCS_ACQ: begin
        if (cnt_r == '0) begin
          state_nxt = MCS_CONV;
          cnt_nxt   = CNT_W'(CONV_CNT - 1);
          flag_nxt  = 1'b1;
          oe_n_nxt  = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      MCS_CONV: begin
        if (cnt_r == '0) begin
          state_nxt = MCS_IDLE;
          flag_nxt  = 1'b0;
          oe_n_nxt  = 1'b0;
          data_nxt  = i_sample_data;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: begin
        state_nxt = MCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r  <= MCS_IDLE;
      cnt_r    <= '0;
      addr_r   <= ADDR_RST;
      data_r   <= '0;
      flag_r   <= 1'b0;
      oe_n_r   <= 1'b1;
      trig_d_r <= 1'b1;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      addr_r   <= addr_nxt;
      data_r   <= data_nxt;
      flag_r   <= flag_nxt;
      oe_n_r   <= oe_n_nxt;
      trig_d_r <= trig_s;
    end
  end

  assign o_conversion_flag   = flag_r;
  assign o_channel_index_out = addr_r;
  assign o_channel_connected = gate_s;
  assign o_data              = data_r;
  assign o_data_oe_n         = oe_n_r;

  property p_load;
    @(posedge i_clk) disable iff (i_sys_rst)
      (trig_fall && !load_n_s && clr_n_s) |=> (addr_r == $past(sel_s & ADDR_MASK));
  endproperty
  a_load: assert property (p_load) else $error("Load did not capture select.");

  property p_step;
    @(posedge i_clk) disable iff (i_sys_rst)
      (trig_fall && load_n_s && clr_n_s) |=> (addr_r == (($past(addr_r) + 4'h1) & ADDR_MASK));
  endproperty
  a_step: assert property (p_step) else $error("Address did not step by one.");

  property p_hold;
    @(posedge i_clk) disable iff (i_sys_rst)
      (!trig_fall && clr_n_s) |=> $stable(addr_r);
  endproperty
  a_hold: assert property (p_hold) else $error("Address moved without a trigger.");

  property p_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
      !clr_n_s |=> (addr_r == ADDR_RST);
  endproperty
  a_clear: assert property (p_clear) else $error("Clear did not force channel zero.");

  property p_range;
    @(posedge i_clk) disable iff (i_sys_rst)
      (addr_r & ~ADDR_MASK) == '0;
  endproperty
  a_range: assert property (p_range) else $error("Address beyond last channel.");

  // Counts the cycles spent acquiring, so that the check on the start of conversion uses a
  // counter rather than a delay as long as the whole acquisition.
  logic [CNT_W-1:0]  acq_len_r;
  logic [CNT_W-1:0]  acq_len_nxt;

  always_comb begin
    acq_len_nxt = acq_len_r;
    if (state_r == MCS_IDLE) begin
      acq_len_nxt = '0;
    end else if (state_r == MCS_ACQ) begin
      acq_len_nxt = acq_len_r + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      acq_len_r <= '0;
    end else begin
      acq_len_r <= acq_len_nxt;
    end
  end

  property p_acq;
    @(posedge i_clk) disable iff (i_sys_rst)
      $rose(flag_r) |-> (acq_len_r == CNT_W'(ACQ_CNT));
  endproperty
  a_acq: assert property (p_acq) else $error("Conversion did not start after acquisition.");

  property p_conv;
    @(posedge i_clk) disable iff (i_sys_rst)
      $rose(flag_r) |-> ##[1:1000] $fell(flag_r);
  endproperty
  a_conv: assert property (p_conv) else $error("Conversion overran its time.");

  property p_valid;
    @(posedge i_clk) disable iff (i_sys_rst)
      $fell(flag_r) |-> (!o_data_oe_n && data_r == $past(i_sample_data));
  endproperty
  a_valid: assert property (p_valid) else $error("Data not valid at end of conversion.");

  property p_flag;
    @(posedge i_clk) disable iff (i_sys_rst)
      $rose(flag_r) |-> ($past(state_r) == MCS_ACQ);
  endproperty
  a_flag: assert property (p_flag) else $error("Flag rose outside acquisition end.");
endmodule

// ### hdl/mcs_pkg.sv
// Package with the constants of the channel sequencer.
package mcs_pkg;
  localparam int          CLK_MHZ        = 100;
  localparam int          ACQ_TIME_NS    = 9000;
  localparam int          CONV_TIME_NS   = 10000;
  localparam int          ACQ_CYCLES     = (ACQ_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int          CONV_CYCLES    = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int          CNT_W          = 14;
  localparam int          ADDR_W         = 4;
  localparam logic [3:0]  ADDR_RST       = 4'h0;
  localparam logic [3:0]  MASK_SE        = 4'hf;
  localparam logic [3:0]  MASK_DIFF      = 4'h7;
  localparam int          DATA_W         = 12;
  typedef enum logic [2:0] {
    MCS_IDLE = 3'b001,
    MCS_ACQ  = 3'b010,
    MCS_CONV = 3'b100
  } mcs_state_t;
endpackage

// ### hdl/mcs_sync.sv
// Two-flop synchroniser for a bus of asynchronous pin levels.
`timescale 1ns/10ps
module mcs_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  // Levels.
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule

// ### testbench/mcs_ctrl_model.sv
// Controller model that can loop the conversion flag back to the trigger pin.
`timescale 1ns/10ps
module mcs_ctrl_model (
  // Controls.
  input  wire logic i_free_run,
  input  wire logic i_trig_n,
  input  wire logic i_flag,
  // Trigger pin.
  output logic      o_trigger_n
);
  // Entering free run while the flag is low gives the first falling edge.
  assign o_trigger_n = i_free_run ? (i_flag & i_trig_n) : i_trig_n;
endmodule

// ### testbench/mcs_sequencer_tb_top.sv
// Testbench of the channel sequencer.
`timescale 1ns/10ps
module mcs_sequencer_tb_top;
  import mcs_pkg::*;
  logic clk = 0, rst = 1, trig_n = 1, load_n = 1, zero_n = 1, gate = 1, free_run = 0;
  logic [3:0] sel = 4'h0;
  logic [11:0] sample = 12'h000;
  logic [11:0] samp_in, data;
  logic trigger_n, flag, conn, oe_n;
  logic [3:0] idx;
  logic [3:0] idx_d;
  int n_mismatch = 0;
  int checked = 0;
  always #5 clk = ~clk;
  assign samp_in = free_run ? {8'h00, idx} : sample;
  mcs_ctrl_model ctl_u (.i_free_run(free_run), .i_trig_n(trig_n), .i_flag(flag),
                        .o_trigger_n(trigger_n));
  mcs_sequencer #(.ACQ_CNT(4), .CONV_CNT(5)) dut_u (
    .i_clk(clk), .i_sys_rst(rst), .i_sample_trigger_n(trigger_n),
    .i_latch_select_n(load_n), .i_counter_zero_n(zero_n), .i_channel_gate_on(gate),
    .i_sel_w8(sel[3]), .i_sel_w4(sel[2]), .i_sel_w2(sel[1]), .i_sel_w1(sel[0]),
    .i_sample_data(samp_in), .o_conversion_flag(flag), .o_channel_index_out(idx),
    .o_channel_connected(conn), .o_data(data), .o_data_oe_n(oe_n));
  mcs_sequencer #(.DIFF_MODE(1'b1), .ACQ_CNT(4), .CONV_CNT(5)) dut_diff_u (
    .i_clk(clk), .i_sys_rst(rst), .i_sample_trigger_n(trigger_n),
    .i_latch_select_n(load_n), .i_counter_zero_n(zero_n), .i_channel_gate_on(gate),
    .i_sel_w8(sel[3]), .i_sel_w4(sel[2]), .i_sel_w2(sel[1]), .i_sel_w1(sel[0]),
    .i_sample_data(sample), .o_conversion_flag(), .o_channel_index_out(idx_d),
    .o_channel_connected(), .o_data(), .o_data_oe_n());
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_flag(input logic v, input int lim);
    int i;
    i = 0;
    while (flag !== v && i < lim) begin
      @(negedge clk);
      i++;
    end
    cmp(12'(flag), 12'(v));
  endtask
  task automatic pulse;
    @(negedge clk) trig_n = 0;
    repeat (3) @(negedge clk);
    trig_n = 1;
    repeat (2) @(negedge clk);
  endtask
  task automatic conv(input logic [11:0] s);
    sample = s;
    cmp(12'(flag), 12'h000);
    wait_flag(1'b1, 3);
    wait_flag(1'b0, 6);
    cmp(data, s);
    cmp(12'(oe_n), 12'h000);
  endtask
  task automatic t_load(input logic [3:0] a);
    load_n = 0;
    sel = a;
    repeat (3) @(negedge clk);
    pulse();
    cmp(12'(idx), 12'(a));
    cmp(12'(idx_d), 12'(a & 4'h7));
    conv({8'h5a, a});
    load_n = 1;
    repeat (3) @(negedge clk);
  endtask
  task automatic t_trig;
    t_load(4'he);
    pulse();
    cmp(12'(idx), 12'h00f);
    cmp(12'(idx_d), 12'h007);
    conv(12'ha5c);
    pulse();
    cmp(12'(idx), 12'h000);
    cmp(12'(idx_d), 12'h000);
    conv(12'h3c1);
  endtask
  task automatic t_gate;
    @(negedge clk) gate = 0;
    repeat (3) @(negedge clk);
    cmp(12'(conn), 12'h000);
    gate = 1;
    repeat (3) @(negedge clk);
    cmp(12'(conn), 12'h001);
  endtask
  task automatic t_clear;
    t_load(4'h9);
    zero_n = 0;
    repeat (4) @(negedge clk);
    cmp(12'(idx), 12'h000);
    zero_n = 1;
    repeat (3) @(negedge clk);
  endtask
  task automatic t_free;
    logic [3:0] e;
    e = idx;
    free_run = 1;
    for (int i = 1; i <= 17; i++) begin
      wait_flag(1'b1, 10);
      wait_flag(1'b0, 8);
      repeat (4) @(negedge clk);
      cmp(12'(idx), 12'(e + 4'(i + 1)));
      cmp(data, 12'(e + 4'(i)));
    end
    free_run = 0;
    repeat (15) @(negedge clk);
  endtask
  task automatic give_verdict;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    repeat (3) @(negedge clk);
    cmp(12'(idx), 12'h000);
    cmp(12'(oe_n), 12'h001);
    t_load(4'h5);
    t_load(4'hf);
    t_trig();
    t_gate();
    t_clear();
    t_free();
    give_verdict();
  end
endmodule
